// ### design/pgm_params.svh
// Register offsets, field positions and factory defaults for the mask block
`ifndef PGM_PARAMS_SVH
`define PGM_PARAMS_SVH
`define PGM_ADDR_W 8
`define PGM_DATA_W 8
`define PGM_OFF_FOUR_RAIL 8'ha6
`define PGM_OFF_FOUR_AUX 8'ha7
`define PGM_OFF_TWO_RAIL 8'ha8
`define PGM_OFF_TWO_AUX 8'ha9
`define PGM_OFF_STATUS 8'haa
`define PGM_BIT_LDO2 7
`define PGM_BIT_SWA 6
`define PGM_BIT_BUCK_HI 5
`define PGM_BIT_BUCK_LO 0
`define PGM_BIT_CONTROL_INPUT_FIVE 7
`define PGM_BIT_CONTROL_INPUT_FOUR 6
`define PGM_BIT_CONTROL_INPUT_TWO 5
`define PGM_BIT_CONTROL_INPUT_ONE 4
`define PGM_BIT_VTT 3
`define PGM_BIT_SHARED 2
`define PGM_BIT_LOAD_SWITCH_B_ONE 1
`define PGM_BIT_LDO3 0
`define PGM_BIT_OUT_FOUR 0
`define PGM_BIT_OUT_TWO 1
`define PGM_VARIANT_W 2
`define PGM_VARIANT_LOAD_SWITCH_B_TWO 2'h3
`define PGM_VAR0_FOUR_RAIL 8'hf7
`define PGM_VAR1_FOUR_RAIL 8'hbf
`define PGM_VAR2_FOUR_RAIL 8'hf7
`define PGM_VAR3_FOUR_RAIL 8'hff
`define PGM_VAR0_FOUR_AUX 8'hbf
`define PGM_VAR1_FOUR_AUX 8'hff
`define PGM_VAR2_FOUR_AUX 8'h7f
`define PGM_VAR3_FOUR_AUX 8'hff
`define PGM_VAR0_TWO_RAIL 8'hdf
`define PGM_VAR1_TWO_RAIL 8'heb
`define PGM_VAR2_TWO_RAIL 8'hdf
`define PGM_VAR3_TWO_RAIL 8'hc0
`define PGM_VAR_TWO_AUX 8'h3f
`define PGM_ZERO8 8'h00
`define PGM_MASK_ALL 8'hff
`endif

// ### design/pgm_pkg.sv
// Types shared by the power-good mask block
package pgm_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pgm_bus_req_t;
	typedef struct packed {
		logic second_aux_ldo;
		logic load_switch_a;
		logic [5:0] step_down_rail;
		logic first_aux_ldo;
		logic third_aux_ldo;
		logic load_switch_b_one;
		logic load_switch_b_two;
		logic ddr_termination_ldo;
	} pgm_rail_pg_t;
	typedef struct packed {
		logic control_input_five;
		logic control_input_four;
		logic control_input_two;
		logic control_input_one;
	} pgm_ctl_pins_t;
endpackage

// ### design/pgm_top.sv
// Power-good output masking with register port
`timescale 1ns/1ps
`include "pgm_params.svh"
// Overview of operation
// - Output four rail mask bit 7 masks second auxiliary LDO.
// - Output four rail mask bit 6 masks load switch A.
// - Output four rail mask bits 5..0 mask step-down rails six..one.
// - Output four aux mask bits 7..4 mask control pins five,four,two,one.
// - Output four aux mask bit 3 masks DDR termination LDO.
// - Aux bit 2 masks load switch B two or first aux LDO by variant.
// - Aux bit 1 masks load switch B one, bit 0 third aux LDO.
// - Output two rail mask uses the same rail layout.
// - Output four rail mask at A6h, variant factory default.
// - Output four aux mask at A7h, variant default, read/write.
// - Output two rail mask at A8h, variant default, read/write.
// - Output two aux mask at A9h, same layout as output four's.
module pgm_top
#(
	parameter logic [1:0] VARIANT = 2'h0
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire pgm_pkg::pgm_bus_req_t bus_req,
	output logic [7:0] rdata,
	input wire pgm_pkg::pgm_rail_pg_t rail_pg_async,
	input wire pgm_pkg::pgm_ctl_pins_t ctl_pins_async,
	output logic pg_output_four,
	output logic pg_output_two
);
	import pgm_pkg::*;
	// Checks below sample on the system clock and sleep in reset
	default clocking cb_sys @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	logic [7:0] four_rail_reg;
	logic [7:0] four_aux_reg;
	logic [7:0] two_rail_reg;
	logic [7:0] two_aux_reg;
	logic [7:0] four_rail_next;
	logic [7:0] four_aux_next;
	logic [7:0] two_rail_next;
	logic [7:0] two_aux_next;
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;
	logic loaded_reg;
	logic four_reg;
	logic two_reg;
	pgm_rail_pg_t rail_s1_reg;
	pgm_rail_pg_t rail_s2_reg;
	pgm_ctl_pins_t ctl_s1_reg;
	pgm_ctl_pins_t ctl_s2_reg;

	// Factory defaults chosen by variant
	logic [7:0] def_four_rail;
	logic [7:0] def_four_aux;
	logic [7:0] def_two_rail;
	assign def_four_rail = (VARIANT == 2'h0) ? `PGM_VAR0_FOUR_RAIL :
		(VARIANT == 2'h1) ? `PGM_VAR1_FOUR_RAIL :
		(VARIANT == 2'h2) ? `PGM_VAR2_FOUR_RAIL : `PGM_VAR3_FOUR_RAIL;
	assign def_four_aux = (VARIANT == 2'h0) ? `PGM_VAR0_FOUR_AUX :
		(VARIANT == 2'h1) ? `PGM_VAR1_FOUR_AUX :
		(VARIANT == 2'h2) ? `PGM_VAR2_FOUR_AUX : `PGM_VAR3_FOUR_AUX;
	assign def_two_rail = (VARIANT == 2'h0) ? `PGM_VAR0_TWO_RAIL :
		(VARIANT == 2'h1) ? `PGM_VAR1_TWO_RAIL :
		(VARIANT == 2'h2) ? `PGM_VAR2_TWO_RAIL : `PGM_VAR3_TWO_RAIL;

	// Address decode
	logic hit_four_rail;
	logic hit_four_aux;
	logic hit_two_rail;
	logic hit_two_aux;
	logic hit_status;
	assign hit_four_rail = bus_req.addr == `PGM_OFF_FOUR_RAIL;
	assign hit_four_aux = bus_req.addr == `PGM_OFF_FOUR_AUX;
	assign hit_two_rail = bus_req.addr == `PGM_OFF_TWO_RAIL;
	assign hit_two_aux = bus_req.addr == `PGM_OFF_TWO_AUX;
	assign hit_status = bus_req.addr == `PGM_OFF_STATUS;

	// Next register values from writes
	assign four_rail_next = (bus_req.wr && hit_four_rail) ?
		bus_req.wdata : four_rail_reg;
	assign four_aux_next = (bus_req.wr && hit_four_aux) ?
		bus_req.wdata : four_aux_reg;
	assign two_rail_next = (bus_req.wr && hit_two_rail) ?
		bus_req.wdata : two_rail_reg;
	assign two_aux_next = (bus_req.wr && hit_two_aux) ?
		bus_req.wdata : two_aux_reg;

	// Status: current output levels in the low bits
	logic [7:0] status_word;
	assign status_word = {6'h00, two_reg, four_reg};

	// Read mux; unmapped addresses read zero
	assign rdata_next = !bus_req.rd ? `PGM_ZERO8 :
		hit_four_rail ? four_rail_reg :
		hit_four_aux ? four_aux_reg :
		hit_two_rail ? two_rail_reg :
		hit_two_aux ? two_aux_reg :
		hit_status ? status_word : `PGM_ZERO8;

	// Masks reset to all-masked, then load factory defaults once
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			four_rail_reg <= `PGM_MASK_ALL;
			four_aux_reg <= `PGM_MASK_ALL;
			two_rail_reg <= `PGM_MASK_ALL;
			two_aux_reg <= `PGM_MASK_ALL;
			loaded_reg <= 1'b0;
		end
		else if (!loaded_reg)
		begin
			four_rail_reg <= def_four_rail;
			four_aux_reg <= def_four_aux;
			two_rail_reg <= def_two_rail;
			two_aux_reg <= `PGM_VAR_TWO_AUX;
			loaded_reg <= 1'b1;
		end
		else
		begin
			four_rail_reg <= four_rail_next;
			four_aux_reg <= four_aux_next;
			two_rail_reg <= two_rail_next;
			two_aux_reg <= two_aux_next;
		end
	end

	// Read data register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rdata_reg <= `PGM_ZERO8;
		else
			rdata_reg <= rdata_next;
	end

	// Two-flop synchronisers for rail and pin inputs
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rail_s1_reg <= '0;
			rail_s2_reg <= '0;
			ctl_s1_reg <= '0;
			ctl_s2_reg <= '0;
		end
		else
		begin
			rail_s1_reg <= rail_pg_async;
			rail_s2_reg <= rail_s1_reg;
			ctl_s1_reg <= ctl_pins_async;
			ctl_s2_reg <= ctl_s1_reg;
		end
	end

	// Rail good vector in mask bit order
	logic [7:0] rail_good;
	logic shared_good;
	logic [7:0] aux_good;
	assign rail_good[`PGM_BIT_LDO2] = rail_s2_reg.second_aux_ldo;
	assign rail_good[`PGM_BIT_SWA] = rail_s2_reg.load_switch_a;
	assign rail_good[`PGM_BIT_BUCK_HI:`PGM_BIT_BUCK_LO] =
		rail_s2_reg.step_down_rail;
	// Shared source differs by variant
	assign shared_good = (VARIANT == `PGM_VARIANT_LOAD_SWITCH_B_TWO) ?
		rail_s2_reg.load_switch_b_two : rail_s2_reg.first_aux_ldo;
	assign aux_good[`PGM_BIT_CONTROL_INPUT_FIVE] = ctl_s2_reg.control_input_five;
	assign aux_good[`PGM_BIT_CONTROL_INPUT_FOUR] = ctl_s2_reg.control_input_four;
	assign aux_good[`PGM_BIT_CONTROL_INPUT_TWO] = ctl_s2_reg.control_input_two;
	assign aux_good[`PGM_BIT_CONTROL_INPUT_ONE] = ctl_s2_reg.control_input_one;
	assign aux_good[`PGM_BIT_VTT] = rail_s2_reg.ddr_termination_ldo;
	assign aux_good[`PGM_BIT_SHARED] = shared_good;
	assign aux_good[`PGM_BIT_LOAD_SWITCH_B_ONE] = rail_s2_reg.load_switch_b_one;
	assign aux_good[`PGM_BIT_LDO3] = rail_s2_reg.third_aux_ldo;

	// Two trees with their own masks
	logic four_good;
	logic two_good;
	pgm_tree u_four
	(
		.rail_mask(four_rail_reg),
		.aux_mask(four_aux_reg),
		.rail_good(rail_good),
		.aux_good(aux_good),
		.good(four_good)
	);
	pgm_tree u_two
	(
		.rail_mask(two_rail_reg),
		.aux_mask(two_aux_reg),
		.rail_good(rail_good),
		.aux_good(aux_good),
		.good(two_good)
	);

	// Registered outputs, held low until defaults are loaded
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			four_reg <= 1'b0;
			two_reg <= 1'b0;
		end
		else
		begin
			four_reg <= loaded_reg & four_good;
			two_reg <= loaded_reg & two_good;
		end
	end

	assign pg_output_four = four_reg;
	assign pg_output_two = two_reg;
	assign rdata = rdata_reg;

	// Tree checks for output four
	AST_FOUR_TREE: assert property (
		pg_output_four |-> $past(&(four_rail_reg | rail_good)) &&
		$past(&(four_aux_reg | aux_good)))
		else $error("output four good with unmasked bad contributor");
	AST_FOUR_ALLGOOD: assert property (
		loaded_reg && (&(four_rail_reg | rail_good)) &&
		(&(four_aux_reg | aux_good)) |=> pg_output_four)
		else $error("output four not good though all contributors good");
	AST_FOUR_MASKED: assert property (
		loaded_reg && (&four_rail_reg) && (&four_aux_reg)
		|=> pg_output_four)
		else $error("output four not good with every contributor masked");
	AST_LDO2_BAD: assert property (
		!four_rail_reg[`PGM_BIT_LDO2] && !rail_s2_reg.second_aux_ldo
		|=> !pg_output_four)
		else $error("unmasked second aux LDO fault ignored");
	AST_SWA_BAD: assert property (
		!four_rail_reg[`PGM_BIT_SWA] && !rail_s2_reg.load_switch_a
		|=> !pg_output_four)
		else $error("unmasked load switch A fault ignored");
	AST_STEP_DOWN_RAIL_ONE_BAD: assert property (
		!four_rail_reg[`PGM_BIT_BUCK_LO] &&
		!rail_s2_reg.step_down_rail[`PGM_BIT_BUCK_LO]
		|=> !pg_output_four)
		else $error("unmasked rail one fault ignored");
	AST_STEP_DOWN_RAIL_SIX_BAD: assert property (
		!four_rail_reg[`PGM_BIT_BUCK_HI] &&
		!rail_s2_reg.step_down_rail[`PGM_BIT_BUCK_HI]
		|=> !pg_output_four)
		else $error("unmasked rail six fault ignored");
	AST_CONTROL_INPUT_FIVE_BAD: assert property (
		!four_aux_reg[`PGM_BIT_CONTROL_INPUT_FIVE] && !ctl_s2_reg.control_input_five
		|=> !pg_output_four)
		else $error("unmasked control five low ignored");
	AST_CONTROL_INPUT_ONE_BAD: assert property (
		!four_aux_reg[`PGM_BIT_CONTROL_INPUT_ONE] && !ctl_s2_reg.control_input_one
		|=> !pg_output_four)
		else $error("unmasked control one low ignored");
	AST_VTT_BAD: assert property (
		!four_aux_reg[`PGM_BIT_VTT] && !rail_s2_reg.ddr_termination_ldo
		|=> !pg_output_four)
		else $error("unmasked termination LDO fault ignored");
	AST_SHARED_BAD: assert property (
		!four_aux_reg[`PGM_BIT_SHARED] && !shared_good |=> !pg_output_four)
		else $error("unmasked shared source fault ignored");
	AST_LOAD_SWITCH_B_ONE_BAD: assert property (
		!four_aux_reg[`PGM_BIT_LOAD_SWITCH_B_ONE] && !rail_s2_reg.load_switch_b_one
		|=> !pg_output_four)
		else $error("unmasked load switch B one fault ignored");
	AST_LDO3_BAD: assert property (
		!four_aux_reg[`PGM_BIT_LDO3] && !rail_s2_reg.third_aux_ldo
		|=> !pg_output_four)
		else $error("unmasked third aux LDO fault ignored");

	// Tree checks for output two
	AST_TWO_TREE: assert property (
		pg_output_two |-> $past(&(two_rail_reg | rail_good)) &&
		$past(&(two_aux_reg | aux_good)))
		else $error("output two good with unmasked bad contributor");
	AST_TWO_ALLGOOD: assert property (
		loaded_reg && (&(two_rail_reg | rail_good)) &&
		(&(two_aux_reg | aux_good)) |=> pg_output_two)
		else $error("output two not good though all contributors good");
	AST_TWO_LDO2_BAD: assert property (
		!two_rail_reg[`PGM_BIT_LDO2] && !rail_s2_reg.second_aux_ldo
		|=> !pg_output_two)
		else $error("output two ignored second aux LDO fault");
	AST_TWO_SWA_BAD: assert property (
		!two_rail_reg[`PGM_BIT_SWA] && !rail_s2_reg.load_switch_a
		|=> !pg_output_two)
		else $error("output two ignored load switch A fault");
	AST_TWO_STEP_DOWN_RAIL_SIX_BAD: assert property (
		!two_rail_reg[`PGM_BIT_BUCK_HI] &&
		!rail_s2_reg.step_down_rail[`PGM_BIT_BUCK_HI]
		|=> !pg_output_two)
		else $error("output two ignored rail six fault");
	AST_TWO_CONTROL_INPUT_FIVE_BAD: assert property (
		!two_aux_reg[`PGM_BIT_CONTROL_INPUT_FIVE] && !ctl_s2_reg.control_input_five
		|=> !pg_output_two)
		else $error("output two ignored control five low");
	AST_TWO_CONTROL_INPUT_FOUR_BAD: assert property (
		!two_aux_reg[`PGM_BIT_CONTROL_INPUT_FOUR] && !ctl_s2_reg.control_input_four
		|=> !pg_output_two)
		else $error("output two ignored control four low");
	AST_TWO_VTT_BAD: assert property (
		!two_aux_reg[`PGM_BIT_VTT] && !rail_s2_reg.ddr_termination_ldo
		|=> !pg_output_two)
		else $error("output two ignored termination LDO fault");
	AST_TWO_SHARED_BAD: assert property (
		!two_aux_reg[`PGM_BIT_SHARED] && !shared_good |=> !pg_output_two)
		else $error("output two ignored shared source fault");

	// Register port checks
	AST_WRITE_READ: assert property (
		loaded_reg && bus_req.wr && hit_four_aux ##1
		bus_req.rd && hit_four_aux && !$past(bus_req.rd) |=>
		rdata == $past(bus_req.wdata, 2))
		else $error("aux mask readback mismatch");
	AST_WRITE_FOUR_RAIL: assert property (
		loaded_reg && bus_req.wr && hit_four_rail
		|=> four_rail_reg == $past(bus_req.wdata))
		else $error("write to output four rail mask lost");
	AST_WRITE_TWO_RAIL: assert property (
		loaded_reg && bus_req.wr && hit_two_rail
		|=> two_rail_reg == $past(bus_req.wdata))
		else $error("write to output two rail mask lost");
	AST_WRITE_TWO_AUX: assert property (
		loaded_reg && bus_req.wr && hit_two_aux
		|=> two_aux_reg == $past(bus_req.wdata))
		else $error("write to output two aux mask lost");
	AST_UNMAPPED_WRITE: assert property (
		loaded_reg && bus_req.wr && !hit_four_rail && !hit_four_aux &&
		!hit_two_rail && !hit_two_aux |=> $stable(four_rail_reg) &&
		$stable(four_aux_reg) && $stable(two_rail_reg) &&
		$stable(two_aux_reg))
		else $error("write to an unmapped address changed a mask");
	AST_READ_FOUR_RAIL: assert property (
		bus_req.rd && hit_four_rail |=> rdata == $past(four_rail_reg))
		else $error("output four rail mask read back wrong");
	AST_READ_TWO_RAIL: assert property (
		bus_req.rd && hit_two_rail |=> rdata == $past(two_rail_reg))
		else $error("output two rail mask read back wrong");
	AST_READ_IDLE: assert property (
		!bus_req.rd |=> rdata == `PGM_ZERO8)
		else $error("read data not zero outside a read");
	AST_DEFAULT: assert property (
		$rose(loaded_reg) |-> four_rail_reg == def_four_rail &&
		four_aux_reg == def_four_aux && two_rail_reg == def_two_rail &&
		two_aux_reg == `PGM_VAR_TWO_AUX)
		else $error("factory default not loaded");
endmodule

// ### design/pgm_tree.sv
// One masked power-good tree: rail mask plus auxiliary mask
`timescale 1ns/1ps
`include "pgm_params.svh"
module pgm_tree
(
	input wire logic [7:0] rail_mask,
	input wire logic [7:0] aux_mask,
	input wire logic [7:0] rail_good,
	input wire logic [7:0] aux_good,
	output logic good
);
	logic [15:0] term;
	genvar i;
	// A contributor passes if it is masked or reports good
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_bit
			assign term[i] = rail_mask[i] | rail_good[i];
			assign term[i + 8] = aux_mask[i] | aux_good[i];
		end
	endgenerate
	assign good = &term;
endmodule

// ### test/pgm_board_model.sv
// Board-side model that drives rail good levels and control pin states
`timescale 1ns/1ps
module pgm_board_model
(
	input wire logic sys_clk,
	input wire pgm_pkg::pgm_rail_pg_t rail_cmd,
	input wire pgm_pkg::pgm_ctl_pins_t ctl_cmd,
	output pgm_pkg::pgm_rail_pg_t rail_pg,
	output pgm_pkg::pgm_ctl_pins_t ctl_pins
);
	import pgm_pkg::*;
	// Levels move a few ns after the edge, as the board is not synchronous
	always @(posedge sys_clk)
	begin
		rail_pg <= #3 rail_cmd;
		ctl_pins <= #3 ctl_cmd;
	end
endmodule

// ### test/tb_power_good_output_masking.sv
// Self-checking bench for the power-good masking block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) \
		begin \
			err_count++; \
			$display("MISMATCH %s exp %h got %h", nm, exp, got); \
		end \
	end
module tb_power_good_output_masking;
	import pgm_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	pgm_bus_req_t bus_req = '0;
	logic [7:0] rdata;
	pgm_rail_pg_t rail_cmd = '1;
	pgm_ctl_pins_t ctl_cmd = '1;
	pgm_rail_pg_t rail_pg;
	pgm_ctl_pins_t ctl_pins;
	logic pg_four;
	logic pg_two;
	logic [7:0] rdata3;
	logic pg_four3;
	logic pg_two3;
	int err_count = 0;
	int num_checks = 0;
	// Mask bit to contributor position in {ctl_cmd, rail_cmd}
	int pos[16] = '{5, 6, 7, 8, 9, 10, 11, 12, 3, 2, 4, 0, 13, 14, 15, 16};

	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;

	pgm_board_model board_u (.sys_clk(sys_clk), .rail_cmd(rail_cmd),
		.ctl_cmd(ctl_cmd), .rail_pg(rail_pg), .ctl_pins(ctl_pins));
	pgm_top #(.VARIANT(2'h0)) dut_u (.sys_clk(sys_clk), .rst(rst),
		.bus_req(bus_req), .rdata(rdata), .rail_pg_async(rail_pg),
		.ctl_pins_async(ctl_pins), .pg_output_four(pg_four),
		.pg_output_two(pg_two));
	// Last variant, whose shared source is load switch B two
	pgm_top #(.VARIANT(2'h3)) dut_var3_u (.sys_clk(sys_clk), .rst(rst),
		.bus_req(bus_req), .rdata(rdata3), .rail_pg_async(rail_pg),
		.ctl_pins_async(ctl_pins), .pg_output_four(pg_four3),
		.pg_output_two(pg_two3));

	// Verdict and end of run
	task automatic stop_test();
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Reset for 20 cycles, then leave room for the defaults to load
	task automatic do_reset();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	// One register write cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	// One read cycle; data stands one cycle, then returns to zero
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		`CHK("rdata", exp, rdata)
		@(posedge sys_clk);
		#1;
		`CHK("rdata_idle", 8'h00, rdata)
	endtask

	// Write, then read the same address in the very next cycle
	task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		bus_req.rd <= 1'b1;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		`CHK("rdata_b2b", d, rdata)
	endtask

	// Let inputs pass the synchronisers, then look at both outputs
	task automatic out_chk(input logic e4, input logic e2);
		repeat (4) @(posedge sys_clk);
		#1;
		`CHK("pg_output_four", e4, pg_four)
		`CHK("pg_output_two", e2, pg_two)
	endtask

	// Factory defaults of the first variant and an unmapped read
	task automatic sc_defaults();
		rd_chk(8'ha6, 8'hf7);
		rd_chk(8'ha7, 8'hbf);
		rd_chk(8'ha8, 8'hdf);
		rd_chk(8'ha9, 8'h3f);
		rd_chk(8'hb0, 8'h00);
		out_chk(1'b1, 1'b1);
		rd_chk(8'haa, 8'h03);
	endtask

	// Last variant: defaults, and load switch B two as the shared source
	task automatic sc_variant();
		logic [7:0] exp3 [3] = '{8'hff, 8'hff, 8'hc0};
		for (int k = 0; k < 3; k++)
		begin
			@(posedge sys_clk);
			bus_req.addr <= 8'ha6 + k[7:0];
			bus_req.rd <= 1'b1;
			@(posedge sys_clk);
			bus_req.rd <= 1'b0;
			#1;
			`CHK("rdata_var3", exp3[k], rdata3)
		end
		`CHK("pg_output_two_var3", 1'b1, pg_two3)
		wr(8'ha7, 8'hfb);
		wr(8'ha8, 8'hff);
		wr(8'ha9, 8'hff);
		rail_cmd.load_switch_b_two <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		`CHK("pg_output_four_var3", 1'b0, pg_four3)
		`CHK("pg_output_four", 1'b1, pg_four)
		rail_cmd.load_switch_b_two <= 1'b1;
		rail_cmd.first_aux_ldo <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		`CHK("pg_output_four_var3", 1'b1, pg_four3)
		`CHK("pg_output_four", 1'b0, pg_four)
		rail_cmd.first_aux_ldo <= 1'b1;
	endtask

	// Each mask bit alone: its contributor counts, all others are ignored
	task automatic sc_tree();
		logic [15:0] m;
		logic [16:0] v;
		logic [7:0] tb_a;
		logic [7:0] ob_a;
		for (int t = 0; t < 2; t++)
			for (int j = 0; j < 16; j++)
			begin
				m = ~(16'h0001 << j);
				tb_a = (t == 1) ? 8'ha8 : 8'ha6;
				ob_a = (t == 1) ? 8'ha6 : 8'ha8;
				wr(tb_a, m[7:0]);
				wr(tb_a + 8'h01, m[15:8]);
				wr(ob_a, 8'hff);
				wr(ob_a + 8'h01, 8'hff);
				v = '1;
				v[pos[j]] = 1'b0;
				{ctl_cmd, rail_cmd} <= v;
				out_chk(t == 1, t == 0);
				v = '0;
				v[pos[j]] = 1'b1;
				{ctl_cmd, rail_cmd} <= v;
				out_chk(1'b1, 1'b1);
			end
	endtask

	// Read/write of every mask, ignored unmapped write, defaults on reset
	task automatic sc_regs();
		wr_rd_chk(8'ha7, 8'h69);
		wr(8'ha6, 8'h5a);
		wr(8'ha7, 8'ha5);
		wr(8'ha8, 8'h3c);
		wr(8'ha9, 8'hc3);
		wr(8'hb1, 8'hff);
		rd_chk(8'ha6, 8'h5a);
		rd_chk(8'ha7, 8'ha5);
		rd_chk(8'ha8, 8'h3c);
		rd_chk(8'ha9, 8'hc3);
		rd_chk(8'hb1, 8'h00);
		do_reset();
		rd_chk(8'ha6, 8'hf7);
		rd_chk(8'ha7, 8'hbf);
		rd_chk(8'ha8, 8'hdf);
		rd_chk(8'ha9, 8'h3f);
	endtask

	// Cut a hung run short
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		err_count++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		do_reset();
		sc_defaults();
		sc_variant();
		sc_tree();
		sc_regs();
		stop_test();
	end
endmodule
